/* design/bct_compare.sv */
`default_nettype none
// Combinational breakpoint comparator.
module bct_compare (
	// Compare registers and controls
	input  wire logic [7:0]                addr_hi,
	input  wire logic [7:0]                addr_lo,
	input  wire logic [7:0]                data_hi,
	input  wire logic [7:0]                data_lo,
	input  wire bct_pkg::bct_mode_type     mode,
	input  wire logic                      range0,
	input  wire logic                      range1,
	input  wire logic                      dbe,
	input  wire logic                      mbh,
	input  wire logic                      mbl,
	// Observed bus
	input  wire bct_pkg::bct_cpubus_type   bus,
	// Result
	output logic                           hit
);
	logic bp0;
	logic bp1;
	logic full_data;

	// Breakpoint 0 uses the address pair; the low byte only when range 0 is set.
	always_comb begin
		bp0 = (bus.addr[15:8] == addr_hi) && (!range0 || bus.addr[7:0] == addr_lo);
		bp1 = 1'b0;
		full_data = 1'b1;
		hit = 1'b0;
		case (mode)
			bct_pkg::MODE_OFF: begin
				hit = 1'b0;
			end
			bct_pkg::MODE_FULL: begin
				// With the data enable off the data registers take no part.
				if (dbe) begin
					full_data = (mbh || bus.data[15:8] == data_hi) && (mbl || bus.data[7:0] == data_lo);
				end
				hit = bus.cycle && bp0 && full_data;
			end
			bct_pkg::MODE_SWI_DUAL, bct_pkg::MODE_BG_DUAL: begin
				// Second address breakpoint is enabled by the data enable bit.
				bp1 = dbe && (bus.addr[15:8] == data_hi) && (!range1 || bus.addr[7:0] == data_lo);
				hit = bus.cycle && (bp0 || bp1);
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end
endmodule
`default_nettype wire

/* design/bct_top.sv */
`default_nettype none
// Summary of operation
// - Address-low byte compares low address byte only when range control zero set.
// - Data-high register matches data high byte in full mode, address high in dual.
// - Data-high use depends on mode, data enable and high mask.
// - Data-low register matches data low byte in full mode, address low in dual.
// - Data-low use depends on mode, data enable, range control one, low mask.
// - Tagging-start command turns strobe and debug pins into tag inputs.
// - Tag-low shares the strobe pin; tag-high shares the debug pin.
// - Tags are latched at each falling edge of the external bus clock.
// - Each tag pin acts alone.
// - Low level marks a byte: high, low, both or none.
// - Tagging works in every operating mode.
// - Entering background debug mode turns tagging off.
// - Serial commands are ignored while tagging is active.
// - Tags travel with their program bytes through the queue.
// - A tagged instruction at queue head enters background mode instead.
// - Mode 00 off, 01 software dual, 10 full data, 11 background dual.
// - Data enable zero keeps data registers out of comparisons.
// - Mask bits drop data bytes from full-mode comparison.
module bct_top (
	// Clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    sys_rst,
	// AHB-Lite slave
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic      [31:0]             hrdata,
	output logic                         hreadyout,
	output logic                         hresp,
	// CPU bus and queue
	input  wire bct_pkg::bct_cpubus_type cpu_bus,
	input  wire logic                    external_bus_clock,
	input  wire logic                    fetch_valid,
	input  wire logic [15:0]             fetch_word,
	input  wire logic                    queue_advance,
	// Shared pins
	input  wire logic                    low_byte_strobe_in,
	input  wire logic                    low_byte_strobe_out,
	input  wire logic                    background_debug_pin_in,
	output logic                         low_byte_strobe_oe_n,
	output logic                         low_byte_strobe_o,
	// Results
	output logic                         break_match,
	output logic                         background_debug_mode,
	output logic                         head_tag_hit,
	output logic                         serial_cmd_accept
);
	// ****************************************************************
	// Register bus
	// ****************************************************************
	logic [7:0] ctl0_q, ctl0_d, ctl1_q, ctl1_d;
	logic [7:0] addr_hi_q, addr_hi_d, addr_lo_q, addr_lo_d;
	logic [7:0] data_hi_q, data_hi_d, data_lo_q, data_lo_d;
	logic       wr_pend_q, wr_pend_d;
	logic [7:0] wr_addr_q, wr_addr_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic       start_cmd, serial_cmd, leave_bg;
	bct_pkg::bct_state_type state_q, state_d;

	// Address phase captured; write data lands in the following cycle.
	always_comb begin
		wr_pend_d = hsel && hready && htrans[1] && hwrite;
		wr_addr_d = (hsel && hready && htrans[1]) ? haddr[9:2] : wr_addr_q;
		hrdata_d = hrdata_q;
		if (hsel && hready && htrans[1] && !hwrite) begin
			hrdata_d = 32'h0000_0000;
			case (haddr[9:2])
				bct_pkg::IDX_CTL0:    hrdata_d[7:0] = ctl0_q;
				bct_pkg::IDX_CTL1:    hrdata_d[7:0] = ctl1_q;
				bct_pkg::IDX_ADDR_HI: hrdata_d[7:0] = addr_hi_q;
				bct_pkg::IDX_ADDR_LO: hrdata_d[7:0] = addr_lo_q;
				bct_pkg::IDX_DATA_HI: hrdata_d[7:0] = data_hi_q;
				bct_pkg::IDX_DATA_LO: hrdata_d[7:0] = data_lo_q;
				bct_pkg::IDX_STATUS:  hrdata_d[7:0] = {5'h00, break_match, state_q};
				default:              hrdata_d = 32'h0000_0000;
			endcase
		end
		ctl0_d = ctl0_q;
		ctl1_d = ctl1_q;
		addr_hi_d = addr_hi_q;
		addr_lo_d = addr_lo_q;
		data_hi_d = data_hi_q;
		data_lo_d = data_lo_q;
		start_cmd = 1'b0;
		serial_cmd = 1'b0;
		leave_bg = 1'b0;
		if (wr_pend_q) begin
			case (wr_addr_q)
				bct_pkg::IDX_CTL0:    ctl0_d = hwdata[7:0] & 8'hCC;
				bct_pkg::IDX_CTL1:    ctl1_d = hwdata[7:0];
				bct_pkg::IDX_ADDR_HI: addr_hi_d = hwdata[7:0];
				bct_pkg::IDX_ADDR_LO: addr_lo_d = hwdata[7:0];
				bct_pkg::IDX_DATA_HI: data_hi_d = hwdata[7:0];
				bct_pkg::IDX_DATA_LO: data_lo_d = hwdata[7:0];
				bct_pkg::IDX_CMD: begin
					start_cmd = hwdata[bct_pkg::CMD_TAG_START];
					serial_cmd = hwdata[bct_pkg::CMD_SERIAL];
					leave_bg = hwdata[bct_pkg::CMD_LEAVE_BG];
				end
				default: ;
			endcase
		end
	end

	// Register update.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ctl0_q <= bct_pkg::REG_RESET;
			ctl1_q <= bct_pkg::REG_RESET;
			addr_hi_q <= bct_pkg::REG_RESET;
			addr_lo_q <= bct_pkg::REG_RESET;
			data_hi_q <= bct_pkg::REG_RESET;
			data_lo_q <= bct_pkg::REG_RESET;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata_q <= 32'h0000_0000;
		end else begin
			ctl0_q <= ctl0_d;
			ctl1_q <= ctl1_d;
			addr_hi_q <= addr_hi_d;
			addr_lo_q <= addr_lo_d;
			data_hi_q <= data_hi_d;
			data_lo_q <= data_lo_d;
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			hrdata_q <= hrdata_d;
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// ****************************************************************
	// Breakpoint compare
	// ****************************************************************
	logic hit;
	logic match_q;

	bct_compare u_cmp (
		.addr_hi (addr_hi_q),
		.addr_lo (addr_lo_q),
		.data_hi (data_hi_q),
		.data_lo (data_lo_q),
		.mode    (bct_pkg::bct_mode_type'(ctl0_q[bct_pkg::CTL0_MODE_LSB +: 2])),
		.range0  (ctl0_q[bct_pkg::CTL0_RANGE0]),
		.range1  (ctl0_q[bct_pkg::CTL0_RANGE1]),
		.dbe     (ctl1_q[bct_pkg::CTL1_DBE]),
		.mbh     (ctl1_q[bct_pkg::CTL1_MBH]),
		.mbl     (ctl1_q[bct_pkg::CTL1_MBL]),
		.bus     (cpu_bus),
		.hit     (hit)
	);
	// byte selection lives in the comparator.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			match_q <= 1'b0;
		end else begin
			match_q <= hit;
		end
	end
	assign break_match = match_q;

	// ****************************************************************
	// Tag sampling, queue and debug state
	// ****************************************************************
	logic bus_clk_q, tag_hi_q, tag_lo_q, tag_hi_d, tag_lo_d;
	logic fall;
	bct_pkg::bct_qentry_type q_q [bct_pkg::QUEUE_DEPTH];
	bct_pkg::bct_qentry_type q_d [bct_pkg::QUEUE_DEPTH];
	logic head_hit_q, head_hit_d, ser_q, ser_d, oe_n_q, oe_n_d, lso_q;
	logic bdm_q;

	// Tags are active low and each pin is kept apart; inputs are synchronous.
	always_comb begin
		fall = bus_clk_q && !external_bus_clock;
		tag_hi_d = tag_hi_q;
		tag_lo_d = tag_lo_q;
		if (fall && state_q == bct_pkg::ST_TAGGING) begin
			tag_hi_d = !background_debug_pin_in;
			tag_lo_d = !low_byte_strobe_in;
		end
		state_d = state_q;
		head_hit_d = 1'b0;
		for (int i = 0; i < bct_pkg::QUEUE_DEPTH; i++) begin
			q_d[i] = q_q[i];
		end
		if (queue_advance) begin
			for (int i = 0; i < bct_pkg::QUEUE_DEPTH - 1; i++) begin
				q_d[i] = q_q[i + 1];
			end
			q_d[bct_pkg::QUEUE_DEPTH - 1] = '{valid: fetch_valid, word: fetch_word,
				tag_hi: tag_hi_d && state_q == bct_pkg::ST_TAGGING,
				tag_lo: tag_lo_d && state_q == bct_pkg::ST_TAGGING};
		end
		case (state_q)
			bct_pkg::ST_NORMAL: begin
				if (start_cmd) state_d = bct_pkg::ST_TAGGING;
			end
			bct_pkg::ST_TAGGING: begin
				if (q_q[0].valid && (q_q[0].tag_hi || q_q[0].tag_lo)) begin
					state_d = bct_pkg::ST_BACKGROUND;
					head_hit_d = 1'b1;
				end
			end
			bct_pkg::ST_BACKGROUND: begin
				if (leave_bg) state_d = bct_pkg::ST_NORMAL;
			end
			default: state_d = bct_pkg::ST_NORMAL;
		endcase
		ser_d = serial_cmd && state_q != bct_pkg::ST_TAGGING;
		// strobe pin released to input while tagging
		oe_n_d = (state_d == bct_pkg::ST_TAGGING);
	end

	// Tag, queue and state registers.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			bus_clk_q <= 1'b0;
			bdm_q <= 1'b0;
			tag_hi_q <= 1'b0;
			tag_lo_q <= 1'b0;
			state_q <= bct_pkg::ST_NORMAL;
			head_hit_q <= 1'b0;
			ser_q <= 1'b0;
			oe_n_q <= 1'b0;
			lso_q <= 1'b0;
			for (int i = 0; i < bct_pkg::QUEUE_DEPTH; i++) begin
				q_q[i] <= '0;
			end
		end else begin
			bus_clk_q <= external_bus_clock;
			// The mode output comes from its own flop so the pin never sees decode glitches.
			bdm_q <= (state_d == bct_pkg::ST_BACKGROUND);
			tag_hi_q <= (state_d == bct_pkg::ST_TAGGING) ? tag_hi_d : 1'b0;
			tag_lo_q <= (state_d == bct_pkg::ST_TAGGING) ? tag_lo_d : 1'b0;
			state_q <= state_d;
			head_hit_q <= head_hit_d;
			ser_q <= ser_d;
			oe_n_q <= oe_n_d;
			lso_q <= low_byte_strobe_out;
			for (int i = 0; i < bct_pkg::QUEUE_DEPTH; i++) begin
				q_q[i] <= (state_d == bct_pkg::ST_BACKGROUND) ? '0 : q_d[i];
			end
		end
	end

	assign background_debug_mode = bdm_q;
	assign head_tag_hit = head_hit_q;
	assign serial_cmd_accept = ser_q;
	assign low_byte_strobe_oe_n = oe_n_q;
	assign low_byte_strobe_o = lso_q;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_tag_off_bg: assert property (@(posedge clk_sys) disable iff (sys_rst)
		background_debug_mode |-> !tag_hi_q && !tag_lo_q) else $error("Tag held in background mode.");
	a_serial_block: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state_q == bct_pkg::ST_TAGGING) |=> !serial_cmd_accept) else $error("Serial accepted while tagging.");
	a_head_enter: assert property (@(posedge clk_sys) disable iff (sys_rst)
		head_tag_hit |-> background_debug_mode) else $error("Head tag did not enter background.");
	a_mode_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(ctl0_q[7:6] == 2'b00) |=> !break_match) else $error("Match with breakpoints off.");
	a_start_tag: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state_q == bct_pkg::ST_NORMAL && start_cmd) |=> low_byte_strobe_oe_n) else $error("Pins not tag inputs.");
	a_reset_clear: assert property (@(posedge clk_sys)
		sys_rst |=> addr_lo_q == 8'h00 && data_hi_q == 8'h00 && data_lo_q == 8'h00) else $error("Register not cleared.");
	a_tag_latch: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(fall && state_q == bct_pkg::ST_TAGGING && state_d == bct_pkg::ST_TAGGING) |=>
		tag_lo_q == !$past(low_byte_strobe_in)) else $error("Tag low not latched.");
	a_match_cycle: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!cpu_bus.cycle |=> !break_match) else $error("Match without bus cycle.");

	// tag enters the queue tail
	// A word taken at the tail while a tag is latched must carry that tag with it.
	sequence s_tag_taken;
		state_q == bct_pkg::ST_TAGGING && state_d == bct_pkg::ST_TAGGING && queue_advance && (tag_hi_d || tag_lo_d);
	endsequence
	sequence s_tail_marked;
		q_q[bct_pkg::QUEUE_DEPTH - 1].tag_hi || q_q[bct_pkg::QUEUE_DEPTH - 1].tag_lo;
	endsequence
	a_tag_carry: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_tag_taken |=> s_tail_marked) else $error("Tag lost at queue tail.");
endmodule
`default_nettype wire

/* pkg/bct_pkg.sv */
`default_nettype none
package bct_pkg;
	// Register indices; the byte address on the bus is four times the index.
	localparam logic [7:0] IDX_CTL0    = 8'h20;
	localparam logic [7:0] IDX_CTL1    = 8'h21;
	localparam logic [7:0] IDX_ADDR_HI = 8'h22;
	localparam logic [7:0] IDX_ADDR_LO = 8'h23;
	localparam logic [7:0] IDX_DATA_HI = 8'h24;
	localparam logic [7:0] IDX_DATA_LO = 8'h25;
	localparam logic [7:0] IDX_STATUS  = 8'h26;
	localparam logic [7:0] IDX_CMD     = 8'h27;
	localparam logic [7:0] REG_RESET   = 8'h00;
	// Control register 0 fields.
	localparam int CTL0_MODE_LSB  = 6;
	localparam int CTL0_RANGE1    = 3;
	localparam int CTL0_RANGE0    = 2;
	// Control register 1 fields.
	localparam int CTL1_DBE       = 6;
	localparam int CTL1_MBH       = 5;
	localparam int CTL1_MBL       = 4;
	// Command register bits.
	localparam int CMD_TAG_START  = 0;
	localparam int CMD_SERIAL     = 1;
	localparam int CMD_LEAVE_BG   = 2;
	// Queue depth in words.
	localparam int QUEUE_DEPTH    = 3;

	typedef enum logic [1:0] {
		MODE_OFF,
		MODE_SWI_DUAL,
		MODE_FULL,
		MODE_BG_DUAL
	} bct_mode_type;

	typedef enum logic [1:0] {
		ST_NORMAL,
		ST_TAGGING,
		ST_BACKGROUND
	} bct_state_type;

	// One queue entry: program word with a tag per byte.
	typedef struct packed {
		logic        valid;
		logic [15:0] word;
		logic        tag_hi;
		logic        tag_lo;
	} bct_qentry_type;

	// CPU bus observed for comparison.
	typedef struct packed {
		logic        cycle;
		logic [15:0] addr;
		logic [15:0] data;
	} bct_cpubus_type;
endpackage
`default_nettype wire

/* tb/bct_tool.sv */
`default_nettype none
// ****************************************
// Debug tool that drives the tag pins
// ****************************************
module bct_tool (
	// Clock
	input  wire logic       clk_sys,
	// Requested tag levels, active low: bit 1 high byte, bit 0 low byte
	input  wire logic [1:0] tag_code_n,
	// Device side of the shared strobe pin
	input  wire logic       strobe_oe_n,
	input  wire logic       strobe_o,
	// Pins
	output logic            bus_clk,
	output logic            tag_lo_pin,
	output logic            tag_hi_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] div_q;
	logic [1:0] tag_q;

	// The bus clock runs free at a quarter of the system clock.
	initial begin
		div_q = 2'h0;
		tag_q = 2'h3;
	end
	assign bus_clk = div_q[1];

	// stable tag levels
	// Tags change only just after a rising bus clock, so they are settled at the fall.
	always @(posedge clk_sys) begin
		div_q <= div_q + 2'h1;
		if (div_q == 2'h1) begin
			tag_q <= tag_code_n;
		end
	end

	// tool drives only while tagging
	// Released pins read high through their pull-ups; the device owns the strobe otherwise.
	assign tag_lo_pin = strobe_oe_n ? tag_q[0] : strobe_o;
	assign tag_hi_pin = strobe_oe_n ? tag_q[1] : 1'h1;
endmodule
`default_nettype wire

/* tb/breakpoint_compare_and_tagging_tb.sv */
`default_nettype none
module breakpoint_compare_and_tagging_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic                   clk_sys, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0]            haddr, hwdata, hrdata;
	logic [1:0]             htrans, tag_code_n;
	logic [2:0]             hsize;
	bct_pkg::bct_cpubus_type cpu_bus;
	logic                   bus_clk, fetch_valid, queue_advance, lo_pin, hi_pin, strobe_out;
	logic [15:0]            fetch_word;
	logic                   strobe_oe_n, strobe_o, break_match, background_debug_mode;
	logic                   head_tag_hit, serial_cmd_accept;
	int                     failures, checks, cycles;

	assign hready = hreadyout;

	bct_top dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .cpu_bus(cpu_bus), .external_bus_clock(bus_clk),
		.fetch_valid(fetch_valid), .fetch_word(fetch_word), .queue_advance(queue_advance),
		.low_byte_strobe_in(lo_pin), .low_byte_strobe_out(strobe_out), .background_debug_pin_in(hi_pin),
		.low_byte_strobe_oe_n(strobe_oe_n), .low_byte_strobe_o(strobe_o), .break_match(break_match),
		.background_debug_mode(background_debug_mode), .head_tag_hit(head_tag_hit),
		.serial_cmd_accept(serial_cmd_accept));

	bct_tool tool_u (.clk_sys(clk_sys), .tag_code_n(tag_code_n), .strobe_oe_n(strobe_oe_n),
		.strobe_o(strobe_o), .bus_clk(bus_clk), .tag_lo_pin(lo_pin), .tag_hi_pin(hi_pin));

	initial begin
		clk_sys = 1'h0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic final_report;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// A hang ends the run as a failure.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			final_report;
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One single word transfer; entered just after a rising edge, ends on one.
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'h1;
		haddr <= {22'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		do @(posedge clk_sys); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_sys); while (hready !== 1'h1);
		rd = hrdata;
	endtask

	// Looks for a one-cycle pulse over a fixed window.
	task automatic watch(input int which, output logic seen);
		seen = 1'h0;
		repeat (24) begin
			#1;
			if ((which == 0 ? serial_cmd_accept : head_tag_hit) === 1'h1) begin
				seen = 1'h1;
			end
			@(posedge clk_sys);
		end
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		logic [31:0] r;
		bus(1'h0, bct_pkg::IDX_ADDR_LO, 32'h0, r);
		chk(r, 32'h0);
		bus(1'h0, bct_pkg::IDX_DATA_HI, 32'h0, r);
		chk(r, 32'h0);
		bus(1'h0, bct_pkg::IDX_DATA_LO, 32'h0, r);
		chk(r, 32'h0);
		bus(1'h0, 8'h30, 32'h0, r);
		chk(r, 32'h0);
		chk(hresp, 1'h0);
		chk(hreadyout, 1'h1);
		chk(strobe_oe_n, 1'h0);
		chk(strobe_o, 1'h1);
		// The strobe copy must follow the internal strobe, not sit at a constant.
		strobe_out <= 1'h0;
		@(posedge clk_sys);
		strobe_out <= 1'h1;
		#1;
		chk(strobe_o, 1'h0);
		@(posedge clk_sys);
		$display("test reset done");
	endtask

	task automatic t_regs;
		logic [31:0] r;
		bus(1'h1, bct_pkg::IDX_ADDR_HI, 32'h12, r);
		bus(1'h1, bct_pkg::IDX_ADDR_LO, 32'h34, r);
		bus(1'h1, bct_pkg::IDX_DATA_LO, 32'hFFFF_FFA5, r);
		bus(1'h0, bct_pkg::IDX_ADDR_LO, 32'h0, r);
		chk(r, 32'h34);
		bus(1'h0, bct_pkg::IDX_DATA_LO, 32'h0, r);
		chk(r, 32'hA5);
		$display("test registers done");
	endtask

	// Sets controls and data compare bytes, shows one bus cycle, expects the match a cycle later.
	task automatic cmp(input logic [7:0] c0, c1, dh, dl, input logic [15:0] a, d, input logic e);
		logic [31:0] r;
		bus(1'h1, bct_pkg::IDX_CTL0, {24'h0, c0}, r);
		bus(1'h1, bct_pkg::IDX_CTL1, {24'h0, c1}, r);
		bus(1'h1, bct_pkg::IDX_DATA_HI, {24'h0, dh}, r);
		bus(1'h1, bct_pkg::IDX_DATA_LO, {24'h0, dl}, r);
		cpu_bus <= '{cycle: 1'h1, addr: a, data: d};
		@(posedge clk_sys);
		cpu_bus.cycle <= 1'h0;
		#1;
		chk(break_match, e);
		@(posedge clk_sys);
	endtask

	task automatic t_cmp;
		cmp(8'h04, 8'h40, 8'h56, 8'h78, 16'h1234, 16'h5678, 1'h0);
		cmp(8'h84, 8'h40, 8'h56, 8'h78, 16'h1234, 16'h5678, 1'h1);
		cmp(8'h84, 8'h40, 8'h56, 8'h78, 16'h1234, 16'hAA78, 1'h0);
		cmp(8'h84, 8'h60, 8'h56, 8'h78, 16'h1234, 16'hAA78, 1'h1);
		cmp(8'h84, 8'h50, 8'h56, 8'h78, 16'h1234, 16'h56AA, 1'h1);
		cmp(8'h80, 8'h00, 8'h56, 8'h78, 16'h12EE, 16'hAAAA, 1'h1);
		cmp(8'h84, 8'h00, 8'h56, 8'h78, 16'h12EE, 16'h0000, 1'h0);
		cmp(8'h4C, 8'h40, 8'h56, 8'h78, 16'h5678, 16'h0000, 1'h1);
		cmp(8'hC4, 8'h40, 8'h56, 8'h78, 16'h56EE, 16'h0000, 1'h1);
		cmp(8'hCC, 8'h00, 8'h56, 8'h78, 16'h5678, 16'h0000, 1'h0);
		$display("test compare done");
	endtask

	task automatic t_serial(input logic exp);
		logic [31:0] r;
		logic        seen;
		bus(1'h1, bct_pkg::IDX_CMD, 32'h2, r);
		watch(0, seen);
		chk(seen, exp);
		$display("test serial done");
	endtask

	task automatic t_tag(input logic [1:0] code, input logic exp);
		logic [31:0] r;
		logic        seen;
		bus(1'h1, bct_pkg::IDX_CMD, 32'h1, r);
		bus(1'h0, bct_pkg::IDX_STATUS, 32'h0, r);
		chk(r & 32'h3, 32'h1);
		chk(strobe_oe_n, 1'h1);
		tag_code_n <= code;
		repeat (12) @(posedge clk_sys);
		fetch_valid <= 1'h1;
		queue_advance <= 1'h1;
		watch(1, seen);
		fetch_valid <= 1'h0;
		queue_advance <= 1'h0;
		chk(seen, exp);
		chk(background_debug_mode, exp);
		// Logical not keeps the expectation one bit wide when it is widened to the word.
		chk(strobe_oe_n, !exp);
		tag_code_n <= 2'h3;
		if (exp === 1'h1) begin
			bus(1'h0, bct_pkg::IDX_STATUS, 32'h0, r);
			chk(r & 32'h3, 32'h2);
			bus(1'h1, bct_pkg::IDX_CMD, 32'h4, r);
		end
		$display("test tag %b done", code);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		failures = 0;
		checks = 0;
		cycles = 0;
		sys_rst = 1'h1;
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		cpu_bus = '0;
		fetch_valid = 1'h0;
		fetch_word = 16'hC3A5;
		queue_advance = 1'h0;
		strobe_out = 1'h1;
		tag_code_n = 2'h3;
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'h0;
		@(posedge clk_sys);
		t_reset;
		t_regs;
		t_cmp;
		t_serial(1'h1);
		t_tag(2'h3, 1'h0);
		t_serial(1'h0);
		t_tag(2'h0, 1'h1);
		t_tag(2'h1, 1'h1);
		t_tag(2'h2, 1'h1);
		final_report;
	end
endmodule
`default_nettype wire
